// File: hw/torque_off_pkg.sv
package torque_off_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS = 10;
	// Times as printed, in their own units
	localparam int unsigned TEST_PULSE_IGNORE_TIME_MS = 1;
	localparam int unsigned TEST_PULSE_SPACING_MS = 10;
	localparam int unsigned MISMATCH_MIN_MS = 120;
	localparam int unsigned MISMATCH_MAX_MS = 240;
	localparam int unsigned SHUTDOWN_LATENCY_MS = 50;
	// Mismatch limit placed mid band
	localparam int unsigned CHANNEL_MISMATCH_LIMIT_MS = (MISMATCH_MIN_MS + MISMATCH_MAX_MS) / 2;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	// Filter must ride through 1 ms pulses; two extra cycles cover the synchroniser slack
	localparam int unsigned FILTER_CYC_DEF = TEST_PULSE_IGNORE_TIME_MS * CYC_PER_MS + 2;
	localparam int unsigned MISMATCH_CYC_DEF = CHANNEL_MISMATCH_LIMIT_MS * CYC_PER_MS;
	localparam int unsigned SUPPLY_CYC_DEF = 1 * CYC_PER_MS;
	localparam int unsigned CNT_W = 32;
	localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
	localparam logic RELAY_CLOSED = 1'b1;
endpackage

// File: hw/demand_filter.sv
`timescale 1ns/1ps
// Ignores low pulses no longer than the ignore time; output low = demand
module demand_filter #(
	parameter int unsigned FILTER_CYC = torque_off_pkg::FILTER_CYC_DEF
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// Synchronised level in, filtered level out
	input  wire logic level_in,
	output logic      level_out
);
	typedef struct packed {
		logic                                  out;
		logic [torque_off_pkg::CNT_W-1:0]      cnt;
	} filt_s;
	filt_s st_ff, nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (level_in) begin
			nxt_st.cnt = torque_off_pkg::CNT_RST;
			nxt_st.out = 1'b1;
		end else if (st_ff.out) begin
			// Low must outlast the ignore time before it counts as demand
			if (st_ff.cnt >= FILTER_CYC[torque_off_pkg::CNT_W-1:0]) begin
				nxt_st.out = 1'b0;
			end else begin
				nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '{out: 1'b0, cnt: torque_off_pkg::CNT_RST};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign level_out = st_ff.out;
endmodule

// File: hw/torque_off_monitor.sv
`timescale 1ns/1ps
// Operation
// - A low input demands torque-off; both high with no fault permits torque.
// - Disagreement shorter than 120 ms never raises a fault.
// - Disagreement longer than 240 ms raises an external fault, torque-off and opens the relay.
// - The mismatch threshold may lie anywhere between 120 ms and 240 ms.
// - Every fault forces torque-off and opens the fault relay.
// - The relay stays closed while no fault has been seen since power-up.
// - A latched fault holds relay open and safe state whatever the inputs do.
// - Torque is cut within 50 ms of the first input demanding it.
// - Low pulses of 1 ms or less spaced 10 ms apart are ignored.
// - Gate isolator supplies disagreeing or out of range is an internal fault.
// - Loss of the input feed supply on overcurrent acts as a torque-off demand.
// - A channel stuck released is only found when the other demands and mismatch persists.
module torque_off_monitor #(
	parameter int unsigned MISMATCH_CYC = torque_off_pkg::MISMATCH_CYC_DEF,
	parameter int unsigned FILTER_CYC   = torque_off_pkg::FILTER_CYC_DEF,
	parameter int unsigned SUPPLY_CYC   = torque_off_pkg::SUPPLY_CYC_DEF
) (
	// Clock and power-on reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// Torque-off demand pins, low = demand
	input  wire logic safe_torque_off_1_n,
	input  wire logic safe_torque_off_2_n,
	// Gate isolator supply monitors, high = in range
	input  wire logic hs_supply_ok,
	input  wire logic ls_supply_ok,
	// Auxiliary input feed, high = healthy
	input  wire logic aux_supply_ok,
	// Outputs
	output logic      torque_enable,
	output logic      fault_relay_contact_a,
	output logic      fault_relay_contact_b,
	output logic      ext_fault,
	output logic      int_fault
);
	typedef enum logic [2:0] {
		ST_BLOCKED = 3'h1,
		ST_RUN     = 3'h2,
		ST_FAULT   = 3'h4
	} mon_e;

	typedef struct packed {
		logic [1:0]                       sync1;
		logic [1:0]                       sync2;
		logic [2:0]                       sup1;
		logic [2:0]                       sup2;
		logic [torque_off_pkg::CNT_W-1:0] mis_cnt;
		logic [torque_off_pkg::CNT_W-1:0] sup_cnt;
		mon_e                             state;
		logic                             ext_f;
		logic                             int_f;
		logic                             torque;
		logic                             relay;
	} mon_s;

	mon_s st_ff, nxt_st;
	logic feed_ok;
	logic ch1_raw;
	logic ch2_raw;
	logic ch1_lvl;
	logic ch2_lvl;
	logic both_released;
	logic mismatch;
	logic sup_low;
	logic sup_diff;
	logic supply_bad;
	logic fault_now;

	// Limits cut to counter width once, so every compare is the same size
	localparam logic [torque_off_pkg::CNT_W-1:0] MIS_LIM =
		MISMATCH_CYC[torque_off_pkg::CNT_W-1:0];
	localparam logic [torque_off_pkg::CNT_W-1:0] SUP_LIM =
		SUPPLY_CYC[torque_off_pkg::CNT_W-1:0];

	// Saturating count: a held condition must never wrap back below its limit
	function automatic logic [torque_off_pkg::CNT_W-1:0] sat_inc(
		input logic [torque_off_pkg::CNT_W-1:0] cnt,
		input logic [torque_off_pkg::CNT_W-1:0] lim
	);
		logic [torque_off_pkg::CNT_W-1:0] res;
		res = cnt;
		if (cnt < lim) begin
			res = cnt + 32'h0000_0001;
		end
		return res;
	endfunction

	// Limit reached once the count stands at or above it
	function automatic logic reached(
		input logic [torque_off_pkg::CNT_W-1:0] cnt,
		input logic [torque_off_pkg::CNT_W-1:0] lim
	);
		return cnt >= lim;
	endfunction

	// Relay level for a state: open only in the fault state
	function automatic logic relay_for(input mon_e s);
		logic lvl;
		lvl = torque_off_pkg::RELAY_CLOSED;
		if (s == ST_FAULT) begin
			lvl = ~torque_off_pkg::RELAY_CLOSED;
		end
		return lvl;
	endfunction

	// Feed loss pulls both channels to demand, after its own synchroniser
	assign feed_ok = st_ff.sup2[2];
	assign ch1_raw = st_ff.sync2[0] & feed_ok;
	assign ch2_raw = st_ff.sync2[1] & feed_ok;

	// One filter per channel, so a test pulse on one input cannot mask the other
	demand_filter #(.FILTER_CYC(FILTER_CYC)) u_filt1 (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.level_in  (ch1_raw),
		.level_out (ch1_lvl)
	);
	demand_filter #(.FILTER_CYC(FILTER_CYC)) u_filt2 (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.level_in  (ch2_raw),
		.level_out (ch2_lvl)
	);

	// Torque needs both filtered channels released
	assign both_released = ch1_lvl & ch2_lvl;

	always_comb begin
		nxt_st = st_ff;
		// Two flops per pin before anything reads it
		nxt_st.sync1 = {safe_torque_off_2_n, safe_torque_off_1_n};
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.sup1 = {aux_supply_ok, ls_supply_ok, hs_supply_ok};
		nxt_st.sup2 = st_ff.sup1;

		// Stuck-released channel shows only here, once the other demands
		mismatch = ch1_lvl ^ ch2_lvl;
		if (mismatch) begin
			nxt_st.mis_cnt = sat_inc(st_ff.mis_cnt, MIS_LIM);
		end else begin
			nxt_st.mis_cnt = torque_off_pkg::CNT_RST;
		end

		// Either isolator group low, or the two groups disagreeing
		sup_low = !st_ff.sup2[0] | !st_ff.sup2[1];
		sup_diff = st_ff.sup2[0] ^ st_ff.sup2[1];
		supply_bad = sup_low | sup_diff;
		// Brief supply glitch tolerated for a short settle time
		if (supply_bad) begin
			nxt_st.sup_cnt = sat_inc(st_ff.sup_cnt, SUP_LIM);
		end else begin
			nxt_st.sup_cnt = torque_off_pkg::CNT_RST;
		end

		// Flags are only ever set here; nothing but reset clears them
		if (reached(st_ff.mis_cnt, MIS_LIM)) begin
			nxt_st.ext_f = 1'b1;
		end
		if (reached(st_ff.sup_cnt, SUP_LIM)) begin
			nxt_st.int_f = 1'b1;
		end
		fault_now = nxt_st.ext_f | nxt_st.int_f;

		// Either filtered channel low blocks torque straight away
		case (st_ff.state)
			ST_BLOCKED: begin
				if (fault_now) begin
					nxt_st.state = ST_FAULT;
				end else if (both_released) begin
					nxt_st.state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (fault_now) begin
					nxt_st.state = ST_FAULT;
				end else if (!both_released) begin
					nxt_st.state = ST_BLOCKED;
				end
			end
			ST_FAULT: begin
				// No input leaves this state, so the operator must see the trip
				nxt_st.state = ST_FAULT;
			end
			default: begin
				nxt_st.state = ST_FAULT;
			end
		endcase

		// Outputs decoded from the next state so they change with it
		nxt_st.torque = (nxt_st.state == ST_RUN);
		nxt_st.relay = relay_for(nxt_st.state);
	end

	// Fault latch leaves ST_FAULT only through reset
	// Zeros in the sync stages read as demand and bad supply, the safe side
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			st_ff <= '{
				sync1:   2'h0,
				sync2:   2'h0,
				sup1:    3'h0,
				sup2:    3'h0,
				mis_cnt: torque_off_pkg::CNT_RST,
				sup_cnt: torque_off_pkg::CNT_RST,
				state:   ST_BLOCKED,
				ext_f:   1'b0,
				int_f:   1'b0,
				torque:  1'b0,
				relay:   torque_off_pkg::RELAY_CLOSED
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Every output comes straight from its register
	assign torque_enable = st_ff.torque;
	assign fault_relay_contact_a = st_ff.relay;
	assign fault_relay_contact_b = st_ff.relay;
	assign ext_fault = st_ff.ext_f;
	assign int_fault = st_ff.int_f;
endmodule

// File: verif/torque_off_monitor_checker.sv
`timescale 1ns/1ps
module torque_off_monitor_checker #(
	parameter int unsigned MISMATCH_CYC = torque_off_pkg::MISMATCH_CYC_DEF,
	parameter int unsigned FILTER_CYC   = torque_off_pkg::FILTER_CYC_DEF,
	parameter int unsigned SUPPLY_CYC   = torque_off_pkg::SUPPLY_CYC_DEF
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Pins
	input wire logic safe_torque_off_1_n,
	input wire logic safe_torque_off_2_n,
	input wire logic hs_supply_ok,
	input wire logic ls_supply_ok,
	input wire logic aux_supply_ok,
	input wire logic torque_enable,
	input wire logic fault_relay_contact_a,
	input wire logic fault_relay_contact_b,
	input wire logic ext_fault,
	input wire logic int_fault
);
	logic [31:0] dcnt_ff;
	logic [31:0] mcnt_ff;
	logic [31:0] scnt_ff;
	wire logic   fault = ext_fault || int_fault;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Run lengths of raw demand, channel mismatch and bad supply
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			dcnt_ff <= '0;
			mcnt_ff <= '0;
			scnt_ff <= '0;
		end else begin
			dcnt_ff <= (!safe_torque_off_1_n || !safe_torque_off_2_n || !aux_supply_ok) ?
				dcnt_ff + 1 : '0;
			mcnt_ff <= (safe_torque_off_1_n != safe_torque_off_2_n) ? mcnt_ff + 1 : '0;
			scnt_ff <= (!hs_supply_ok || !ls_supply_ok) ? scnt_ff + 1 : '0;
		end
	end
	a_relay_pair: assert property (fault_relay_contact_a == fault_relay_contact_b)
		else $error("relay contacts differ");
	a_relay_cause: assert property (!fault_relay_contact_a |-> fault)
		else $error("relay open without fault");
	a_fault_open: assert property (fault |-> ##3 (!fault_relay_contact_a && !torque_enable))
		else $error("fault did not open relay and cut torque");
	a_fault_sticky: assert property (!$fell(ext_fault) && !$fell(int_fault))
		else $error("latched fault cleared");
	a_demand_cut: assert property (dcnt_ff > FILTER_CYC + 8 |-> !torque_enable)
		else $error("torque not cut after demand");
	a_mismatch_trip: assert property (mcnt_ff == MISMATCH_CYC + FILTER_CYC + 12 |-> ext_fault)
		else $error("long mismatch without fault");
	a_supply_trip: assert property (scnt_ff == SUPPLY_CYC + 6 |-> int_fault)
		else $error("bad supply without fault");
	a_torque_rise: assert property ($rose(torque_enable) |->
		$past(safe_torque_off_1_n, 3) && $past(safe_torque_off_2_n, 3) &&
		$past(aux_supply_ok, 3) && !fault)
		else $error("torque rose without release");
endmodule
bind torque_off_monitor torque_off_monitor_checker #(.MISMATCH_CYC(MISMATCH_CYC),
	.FILTER_CYC(FILTER_CYC), .SUPPLY_CYC(SUPPLY_CYC)) chk (.*);

// File: verif/safety_ctrl.sv
`timescale 1ns/1ps
module safety_ctrl (
	// Clock and demand from the bench
	input  wire logic       ref_clk,
	input  wire logic       demand,
	input  wire logic [9:0] skew,
	input  wire logic       stuck,
	// Demand pins, low = demand
	output logic            ch1_n,
	output logic            ch2_n
);
	logic [9:0] age  = 10'h000;
	logic       last = 1'b0;
	initial {ch1_n, ch2_n} = 2'b11;
	// Channel 2 lags by skew cycles, like a slow contact
	always @(posedge ref_clk) begin
		age = (demand == last && age != 10'h3ff) ? age + 10'h001 : 10'h000;
		last = demand;
		ch1_n <= #1 !demand;
		if (stuck) ch2_n <= #1 1'b1;
		else if (age >= skew) ch2_n <= #1 !demand;
	end
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic        ref_clk = 1'b0;
	logic        rstn    = 1'b0;
	logic        demand  = 1'b0;
	logic        stuck   = 1'b0;
	logic [9:0]  skew    = 10'h000;
	logic        hs      = 1'b1;
	logic        ls      = 1'b1;
	logic        aux     = 1'b1;
	logic        watch   = 1'b0;
	logic        drop    = 1'b0;
	logic [31:0] rnd     = 32'hc2636a8f;
	logic        s1_n, s2_n, torque, ra, rb, ef, inf;
	wire logic [4:0] outs = {torque, ra, rb, ef, inf};
	int          fails   = 0;
	int          checked = 0;
	int          cycles  = 0;
	initial forever #5 ref_clk = ~ref_clk;
	safety_ctrl pc (.ref_clk(ref_clk), .demand(demand), .skew(skew), .stuck(stuck),
		.ch1_n(s1_n), .ch2_n(s2_n));
	torque_off_monitor #(.MISMATCH_CYC(200), .FILTER_CYC(10), .SUPPLY_CYC(10)) uut (
		.ref_clk(ref_clk), .rstn(rstn), .safe_torque_off_1_n(s1_n), .safe_torque_off_2_n(s2_n),
		.hs_supply_ok(hs), .ls_supply_ok(ls), .aux_supply_ok(aux), .torque_enable(torque),
		.fault_relay_contact_a(ra), .fault_relay_contact_b(rb), .ext_fault(ef), .int_fault(inf));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [4:0] expect_outs(input logic e, input logic i, input logic d);
		logic rl;
		rl = (e || i) ? ~torque_off_pkg::RELAY_CLOSED : torque_off_pkg::RELAY_CLOSED;
		return {!(e || i) && !d, rl, rl, e, i};
	endfunction
	task automatic check(input logic [4:0] seen, input logic [4:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (watch && !torque) drop = 1'b1;
		if (cycles == 20000) begin
			fails++;
			close_out();
		end
	end
	initial begin
		cyc(12);
		rstn = 1'b1;
		cyc(20);
		check(outs, expect_outs(0, 0, 0));
		watch = 1'b1;
		// Random test pulses, each no longer than the ignore time
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			demand = 1'b1;
			cyc((k == 0) ? 10 : 1 + rnd[2:0]);
			demand = 1'b0;
			cyc(100 + rnd[9:4]);
		end
		watch = 1'b0;
		check({4'h0, drop}, 5'h00);
		skew = 10'h064;
		demand = 1'b1;
		cyc(150);
		check(outs, expect_outs(0, 0, 1));
		demand = 1'b0;
		cyc(150);
		check(outs, expect_outs(0, 0, 0));
		aux = 1'b0;
		cyc(30);
		check(outs, expect_outs(0, 0, 1));
		aux = 1'b1;
		stuck = 1'b1;
		cyc(300);
		check(outs, expect_outs(0, 0, 0));
		demand = 1'b1;
		cyc(300);
		check(outs, expect_outs(1, 0, 1));
		{stuck, demand, skew} = 12'h000;
		cyc(100);
		check(outs, expect_outs(1, 0, 0));
		rstn = 1'b0;
		cyc(2);
		rstn = 1'b1;
		cyc(20);
		check(outs, expect_outs(0, 0, 0));
		hs = 1'b0;
		cyc(5);
		hs = 1'b1;
		cyc(20);
		check(outs, expect_outs(0, 0, 0));
		ls = 1'b0;
		cyc(30);
		check(outs, expect_outs(0, 1, 0));
		close_out();
	end
endmodule
